// *** smosd_consts.vh ***
`ifndef SMOSD_CONSTS_VH
`define SMOSD_CONSTS_VH
// register byte offsets
`define SMOSD_A_CM0 8'h00
`define SMOSD_A_CM1 8'h04
`define SMOSD_A_OSD 8'h08
`define SMOSD_A_FRA 8'h0c
`define SMOSD_A_VM1 8'h10
`define SMOSD_A_VM2 8'h14
`define SMOSD_A_WAKE 8'h18
`define SMOSD_A_STAT 8'h1c
// reset values
`define SMOSD_RST_CM0 8'h48
`define SMOSD_RST_CM1 8'h20
`define SMOSD_RST_WAKE 16'h0000
// clock_mode_reg_0 fields
`define SMOSD_CM0_SUBSEL 1
`define SMOSD_CM0_WAITSTOP 2
`define SMOSD_CM0_SUBDRV 3
`define SMOSD_CM0_SUBEN 4
`define SMOSD_CM0_MAINSTOP 5
`define SMOSD_CM0_DIV8 6
// clock_mode_reg_1 fields
`define SMOSD_CM1_ALLSTOP 0
`define SMOSD_CM1_PINSEL 3
`define SMOSD_CM1_LOWOFF 4
`define SMOSD_CM1_MAINDRV 5
// osc_stop_detect_reg fields
`define SMOSD_OSD_EN_LO 0
`define SMOSD_OSD_EN_HI 1
`define SMOSD_OSD_FALLBK 2
`define SMOSD_OSD_STOPPED 3
// fast_osc_control_reg fields
`define SMOSD_FRA_ON 0
`define SMOSD_FRA_SEL 1
// vmon control fields
`define SMOSD_VM_FDIS 1
`define SMOSD_VM_FLAG 2
`define SMOSD_VM_WDT 3
// wake config fields: filter/mode low byte, enables high byte
`define SMOSD_WK_FILT0 0
`define SMOSD_WK_FILT1 1
`define SMOSD_WK_FILT3 3
`define SMOSD_WK_TFILT 4
`define SMOSD_WK_TEVENT 5
`define SMOSD_WK_SEREXT 6
`define SMOSD_WK_EN 8
// timing
`define SMOSD_CLK_MHZ 50
`define SMOSD_WATCH_NS 1000
`define SMOSD_WATCH_CYC ((`SMOSD_WATCH_NS * `SMOSD_CLK_MHZ) / 1000)
`define SMOSD_SETTLE_NS 2000
`define SMOSD_SETTLE_CYC ((`SMOSD_SETTLE_NS * `SMOSD_CLK_MHZ + 999) / 1000)
`endif

// *** smosd_monitor.sv ***
`timescale 1ns/1ps
// watches stop entry, wake and the stop detector at the top ports
module smosd_monitor #(
  parameter WATCH_CYC = 8,
  parameter SETTLE_CYC = 4
) (
  input wire clk_i, // clock
  input wire reset_i, // sync reset
  input wire main_osc_run_o, // main osc enable
  input wire sub_osc_run_o, // sub osc enable
  input wire low_osc_run_o, // low osc enable
  input wire fast_osc_run_o, // fast osc enable
  input wire main_high_drive_o, // main drive
  input wire sub_high_drive_o, // sub drive
  input wire cpu_clk_run_o, // cpu gate
  input wire periph_clk_run_o, // periph gate
  input wire cpu_div8_o, // divide by 8
  input wire cpu_fallback_o, // on-chip osc
  input wire pin_hold_o, // pin freeze
  input wire main_osc_pin_o, // main pin level
  input wire main_osc_pin_oe_o, // main pin enable
  input wire sub_osc_pin_o, // sub pin level
  input wire sub_osc_pin_oe_o, // sub pin enable
  input wire wake_irq_o, // wake pulse
  input wire osc_stop_irq_o, // detect pulse
  input wire nmi_o // shared vector
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // every oscillator and the peripheral clock are gone on the first stopped cycle
  a_stop_all_off:
    assert property ($rose(pin_hold_o) |-> !(main_osc_run_o | sub_osc_run_o | low_osc_run_o | fast_osc_run_o
      | periph_clk_run_o)) else $error("clock left running in stop");
  a_stop_forces_bits:
    assert property ($rose(pin_hold_o) |-> cpu_div8_o && main_high_drive_o && sub_high_drive_o)
    else $error("stop entry did not force drive and divide bits");
  a_hold_while_off:
    assert property (!cpu_clk_run_o |-> pin_hold_o) else $error("pins released while cpu stopped");
  a_main_pin_high:
    assert property (main_osc_pin_oe_o |-> pin_hold_o && main_osc_pin_o && !sub_osc_pin_oe_o)
    else $error("main osc pin driven outside stop");
  a_sub_pin_high:
    assert property (sub_osc_pin_oe_o |-> pin_hold_o && sub_osc_pin_o) else $error("sub osc pin driven outside stop");
  // settle time is short here, so a wake must reach run quickly
  a_wake_settles:
    assert property ($rose(main_osc_run_o) && pin_hold_o |-> ##[1:12] cpu_clk_run_o) else $error("wake never ran");
  a_wake_irq_at_run:
    assert property ($rose(cpu_clk_run_o) |-> wake_irq_o && cpu_div8_o) else $error("no wake pulse at restart");
  a_wake_pulse_once:
    assert property (wake_irq_o |=> !wake_irq_o) else $error("wake pulse too long");
  a_detect_effects:
    assert property ($rose(cpu_fallback_o) |-> low_osc_run_o && nmi_o && osc_stop_irq_o)
    else $error("fallback without its side effects");
  a_stop_irq_cause:
    assert property (osc_stop_irq_o |-> cpu_fallback_o && nmi_o ##1 !osc_stop_irq_o) else $error("stray stop irq");
endmodule // smosd_monitor
bind smosd_stop_ctrl smosd_monitor #(.WATCH_CYC(WATCH_CYC), .SETTLE_CYC(SETTLE_CYC)) smosd_monitor_i (
  .clk_i(clk_i), .reset_i(reset_i), .main_osc_run_o(main_osc_run_o), .sub_osc_run_o(sub_osc_run_o),
  .low_osc_run_o(low_osc_run_o), .fast_osc_run_o(fast_osc_run_o), .main_high_drive_o(main_high_drive_o),
  .sub_high_drive_o(sub_high_drive_o), .cpu_clk_run_o(cpu_clk_run_o), .periph_clk_run_o(periph_clk_run_o),
  .cpu_div8_o(cpu_div8_o), .cpu_fallback_o(cpu_fallback_o), .pin_hold_o(pin_hold_o),
  .main_osc_pin_o(main_osc_pin_o), .main_osc_pin_oe_o(main_osc_pin_oe_o), .sub_osc_pin_o(sub_osc_pin_o),
  .sub_osc_pin_oe_o(sub_osc_pin_oe_o), .wake_irq_o(wake_irq_o), .osc_stop_irq_o(osc_stop_irq_o), .nmi_o(nmi_o));

// *** smosd_osc_watch.v ***
`timescale 1ns/1ps
module smosd_osc_watch #(
  parameter WIN = 50
) (
  input wire clk_i, // system clock
  input wire reset_i, // sync reset
  input wire en_i, // watch armed
  input wire osc_s_i, // synced oscillator level
  output reg stopped_o // no edge seen for WIN cycles
);
  reg prev_r;
  reg [12:0] cnt_r;
  // any edge restarts the window; disarm clears the verdict
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_r <= 1'b0;
      cnt_r <= 13'h0000;
      stopped_o <= 1'b0;
    end else begin
      prev_r <= osc_s_i;
      if (!en_i || prev_r != osc_s_i) begin
        cnt_r <= 13'h0000;
        stopped_o <= 1'b0;
      end else if (cnt_r == WIN[12:0] - 13'h0001) begin
        stopped_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 13'h0001;
      end
    end
  end
endmodule // smosd_osc_watch

// *** smosd_stop_ctrl.v ***
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "smosd_consts.vh"
// How it works
// RQ1: stop mode halts every oscillator and clock
// RQ2: externally clocked peripherals may still wake
// RQ3: key always wakes; ext 0,1,3 unfiltered
// RQ4: event timer wakes unfiltered in event mode
// RQ5: serial wakes only on external clock
// RQ6: monitors wake only with filter disabled
// RQ7: stop write forces div8 and drive bits
// RQ8: software clears detect enables before stop
// RQ9: pins hold state while stopped
// RQ10: main select: output pin high or input
// RQ11: sub select: sub pin high or input
// RQ12: reset or enabled interrupt ends stop
// RQ13: software sets priorities, global enable, peripheral
// RQ14: interrupt runs after clock restart
// RQ15: wake resumes on system clock div8
// RQ16: detection active only with enables 11b
// RQ17: main stop sets fallback, flag, low osc, irq
// RQ18: software disables detection below 2 MHz
// RQ19: shared vector with identifying flags
// RQ20: software switches back to main clock
// RQ21: software keeps peripheral clock in wait
// RQ22: software disables detection when touching main osc
// RQ23: software picks fallback oscillator before enabling
module smosd_stop_ctrl #(
  parameter WATCH_CYC = `SMOSD_WATCH_CYC,
  parameter SETTLE_CYC = `SMOSD_SETTLE_CYC
) (
  input wire clk_i, // always-on clock
  input wire reset_i, // sync reset, high
  input wire hsel_i, // ahb select
  input wire [7:0] haddr_i, // ahb address
  input wire [1:0] htrans_i, // ahb transfer type
  input wire hwrite_i, // ahb write
  input wire [2:0] hsize_i, // ahb size, word only
  input wire [31:0] hwdata_i, // ahb write data
  input wire hready_i, // ahb bus ready
  output wire hreadyout_o, // ahb slave ready
  output reg [31:0] hrdata_o, // ahb read data
  output wire hresp_o, // ahb response, okay
  input wire key_irq_i, // key input interrupt
  input wire ext_irq_0_i, // external irq 0
  input wire ext_irq_1_i, // external irq 1
  input wire ext_irq_3_i, // external irq 3
  input wire event_timer_irq_i, // event timer irq
  input wire serial_irq_i, // serial interface irq
  input wire vmon1_irq_i, // voltage monitor 1 event
  input wire vmon2_irq_i, // voltage monitor 2 event
  input wire watchdog_irq_i, // watchdog event
  input wire main_clock_in_i, // main crystal clock level
  output wire main_osc_run_o, // main oscillator enable
  output wire sub_osc_run_o, // sub oscillator enable
  output wire low_osc_run_o, // low-speed osc enable
  output wire fast_osc_run_o, // fast osc enable
  output wire fast_osc_sel_o, // fast osc selected
  output wire main_high_drive_o, // main osc high drive
  output wire sub_high_drive_o, // sub osc high drive
  output wire cpu_clk_run_o, // cpu clock gate
  output wire periph_clk_run_o, // peripheral clock gate
  output wire cpu_div8_o, // cpu clock divide by 8
  output wire cpu_fallback_o, // cpu on on-chip osc
  output wire pin_hold_o, // freeze port pin state
  output wire main_osc_pin_o, // main osc output pin level
  output wire main_osc_pin_oe_o, // main osc pin enable
  output wire sub_osc_pin_o, // sub osc output pin level
  output wire sub_osc_pin_oe_o, // sub osc pin enable
  output reg wake_irq_o, // wake interrupt pulse
  output reg [7:0] wake_src_o, // sources that woke
  output reg osc_stop_irq_o, // osc stop event pulse
  output wire nmi_o // shared vector request
);
  localparam ST_RUN = 2'd0;
  localparam ST_STOP = 2'd1;
  localparam ST_WAKE = 2'd2;
  localparam NSRC = 8;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [12:0] settle_r;
  reg [7:0] cm0_r;
  reg [7:0] cm1_r;
  reg [3:0] osd_r;
  reg [1:0] fra_r;
  reg vm1_fdis_r;
  reg vm1_flag_r;
  reg vm2_fdis_r;
  reg vm2_flag_r;
  reg wdt_flag_r;
  reg [15:0] wake_r;
  reg wr_pend_r;
  reg rd_wait_r;
  reg [7:0] addr_r;
  reg [31:0] rd_mux;
  reg stopped_q_r;

  wire [9:0] in_s;
  wire main_clk_s;
  wire [NSRC-1:0] src_s;
  wire [NSRC-1:0] src_ok;
  wire [NSRC-1:0] src_hit;
  wire stopped;
  wire watch_en;
  wire osd_armed;
  wire detect_evt;
  wire running;
  wire acc;
  wire stop_req;

  // pins and other-domain events pass two flops
  smosd_sync2 #(
    .W(10)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({main_clock_in_i, watchdog_irq_i, vmon2_irq_i, vmon1_irq_i,
          serial_irq_i, event_timer_irq_i, ext_irq_3_i, ext_irq_1_i,
          ext_irq_0_i, key_irq_i}),
    .q_o(in_s)
  );
  assign src_s = in_s[7:0];
  assign main_clk_s = in_s[9];

  // wake qualification per source
  assign src_ok[0] = 1'b1; // see RQ3
  assign src_ok[1] = ~wake_r[`SMOSD_WK_FILT0]; // see RQ3
  assign src_ok[2] = ~wake_r[`SMOSD_WK_FILT1]; // see RQ3
  assign src_ok[3] = ~wake_r[`SMOSD_WK_FILT3]; // see RQ3
  assign src_ok[4] = ~wake_r[`SMOSD_WK_TFILT] & wake_r[`SMOSD_WK_TEVENT]; // see RQ4
  assign src_ok[5] = wake_r[`SMOSD_WK_SEREXT]; // see RQ5
  assign src_ok[6] = vm1_fdis_r; // see RQ6
  assign src_ok[7] = vm2_fdis_r; // see RQ6

  // externally clocked requests stay live while stopped
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
      assign src_hit[gi] = src_s[gi] & src_ok[gi] & wake_r[`SMOSD_WK_EN + gi]; // see RQ2
    end
  endgenerate

  // detector armed only on 11b with main clock feeding cpu
  assign osd_armed = osd_r[`SMOSD_OSD_EN_HI] & osd_r[`SMOSD_OSD_EN_LO]; // see RQ16
  assign watch_en = osd_armed & (state_r == ST_RUN) & ~cm0_r[`SMOSD_CM0_SUBSEL] &
                    ~osd_r[`SMOSD_OSD_FALLBK];
  assign detect_evt = stopped & ~stopped_q_r; // see RQ17

  smosd_osc_watch #(
    .WIN(WATCH_CYC)
  ) u_watch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(watch_en),
    .osc_s_i(main_clk_s),
    .stopped_o(stopped)
  );

  // ahb address phase accept
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = ~rd_wait_r;
  assign hresp_o = 1'b0;
  assign stop_req = wr_pend_r & (addr_r == `SMOSD_A_CM1) & hwdata_i[`SMOSD_CM1_ALLSTOP];

  // read mux, unmapped reads zero
  always @* begin
    rd_mux = 32'h00000000;
    case (addr_r)
      `SMOSD_A_CM0: rd_mux[7:0] = cm0_r;
      `SMOSD_A_CM1: rd_mux[7:0] = cm1_r;
      `SMOSD_A_OSD: rd_mux[3:0] = osd_r;
      `SMOSD_A_FRA: rd_mux[1:0] = fra_r;
      `SMOSD_A_VM1: rd_mux[2:1] = {vm1_flag_r, vm1_fdis_r};
      `SMOSD_A_VM2: rd_mux[3:1] = {wdt_flag_r, vm2_flag_r, vm2_fdis_r};
      `SMOSD_A_WAKE: rd_mux[15:0] = wake_r;
      `SMOSD_A_STAT: rd_mux[9:0] = {stopped, main_clk_s, wake_src_o};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // bus phases: writes zero wait, reads one wait state
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_o <= 32'h00000000;
    end else begin
      if (rd_wait_r) begin
        hrdata_o <= rd_mux;
        rd_wait_r <= 1'b0;
        wr_pend_r <= 1'b0;
      end else begin
        wr_pend_r <= acc & hwrite_i;
        rd_wait_r <= acc & ~hwrite_i;
        if (acc) begin
          addr_r <= {haddr_i[7:2], 2'b00};
        end
      end
    end
  end

  // power state sequence
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_req) begin
          state_nxt = ST_STOP; // see RQ1
        end
      end
      ST_STOP: begin
        if (|src_hit) begin
          state_nxt = ST_WAKE; // see RQ12
        end
      end
      ST_WAKE: begin
        if (settle_r == SETTLE_CYC[12:0] - 13'h0001) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // oscillator restart settle count and wake pulse
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_RUN;
      settle_r <= 13'h0000;
      wake_irq_o <= 1'b0;
      wake_src_o <= 8'h00;
    end else begin
      state_r <= state_nxt;
      wake_irq_o <= 1'b0;
      if (state_r == ST_STOP && state_nxt == ST_WAKE) begin
        wake_src_o <= src_hit;
      end
      if (state_r == ST_WAKE) begin
        settle_r <= settle_r + 13'h0001;
      end else begin
        settle_r <= 13'h0000;
      end
      // interrupt only once the cpu clock is back
      if (state_r == ST_WAKE && state_nxt == ST_RUN) begin
        wake_irq_o <= 1'b1; // see RQ14
      end
    end
  end

  // clock control registers; hardware events beat writes
  always @(posedge clk_i) begin
    if (reset_i) begin
      cm0_r <= `SMOSD_RST_CM0;
      cm1_r <= `SMOSD_RST_CM1;
      osd_r <= 4'h0;
      fra_r <= 2'b00;
      wake_r <= `SMOSD_RST_WAKE;
      vm1_fdis_r <= 1'b0;
      vm2_fdis_r <= 1'b0;
      stopped_q_r <= 1'b0;
      osc_stop_irq_o <= 1'b0;
    end else begin
      stopped_q_r <= stopped;
      osc_stop_irq_o <= detect_evt; // see RQ17
      if (wr_pend_r) begin
        case (addr_r)
          `SMOSD_A_CM0: cm0_r <= hwdata_i[7:0];
          `SMOSD_A_CM1: begin
            cm1_r <= hwdata_i[7:0];
            if (hwdata_i[`SMOSD_CM1_ALLSTOP] && state_r == ST_RUN) begin
              cm0_r[`SMOSD_CM0_DIV8] <= 1'b1; // see RQ7
              cm0_r[`SMOSD_CM0_SUBDRV] <= 1'b1; // see RQ7
              cm1_r[`SMOSD_CM1_MAINDRV] <= 1'b1; // see RQ7
            end
          end
          `SMOSD_A_OSD: osd_r[2:0] <= hwdata_i[2:0];
          `SMOSD_A_FRA: fra_r <= hwdata_i[1:0];
          `SMOSD_A_VM1: vm1_fdis_r <= hwdata_i[`SMOSD_VM_FDIS];
          `SMOSD_A_VM2: vm2_fdis_r <= hwdata_i[`SMOSD_VM_FDIS];
          `SMOSD_A_WAKE: wake_r <= hwdata_i[15:0];
          default: wake_r <= wake_r;
        endcase
      end
      // stopped flag: software clears with 0, detection wins
      if (wr_pend_r && addr_r == `SMOSD_A_OSD && !hwdata_i[`SMOSD_OSD_STOPPED]) begin
        osd_r[`SMOSD_OSD_STOPPED] <= 1'b0;
      end
      // stop bit drops as the clocks come back
      if (state_r == ST_WAKE && state_nxt == ST_RUN) begin
        cm1_r[`SMOSD_CM1_ALLSTOP] <= 1'b0; // see RQ15
      end
      // fallback to on-chip osc; no automatic return
      if (detect_evt) begin
        osd_r[`SMOSD_OSD_FALLBK] <= 1'b1; // see RQ17
        osd_r[`SMOSD_OSD_STOPPED] <= 1'b1; // see RQ17
        cm1_r[`SMOSD_CM1_LOWOFF] <= 1'b0; // see RQ17
      end
    end
  end

  // shared vector cause flags, set beats clear
  always @(posedge clk_i) begin
    if (reset_i) begin
      vm1_flag_r <= 1'b0;
      vm2_flag_r <= 1'b0;
      wdt_flag_r <= 1'b0;
    end else begin
      if (in_s[6]) begin
        vm1_flag_r <= 1'b1;
      end else if (wr_pend_r && addr_r == `SMOSD_A_VM1 && !hwdata_i[`SMOSD_VM_FLAG]) begin
        vm1_flag_r <= 1'b0;
      end
      if (in_s[7]) begin
        vm2_flag_r <= 1'b1;
      end else if (wr_pend_r && addr_r == `SMOSD_A_VM2 && !hwdata_i[`SMOSD_VM_FLAG]) begin
        vm2_flag_r <= 1'b0;
      end
      if (in_s[8]) begin
        wdt_flag_r <= 1'b1;
      end else if (wr_pend_r && addr_r == `SMOSD_A_VM2 && !hwdata_i[`SMOSD_VM_WDT]) begin
        wdt_flag_r <= 1'b0;
      end
    end
  end

  // one vector for four causes
  assign nmi_o = osd_r[`SMOSD_OSD_STOPPED] | (osd_armed & osd_r[`SMOSD_OSD_FALLBK]) |
                 wdt_flag_r | vm1_flag_r | vm2_flag_r; // see RQ19

  // oscillators and clocks all off outside run and wake
  assign running = (state_r == ST_RUN) | (state_r == ST_WAKE);
  assign main_osc_run_o = running & ~cm0_r[`SMOSD_CM0_MAINSTOP]; // see RQ1
  assign sub_osc_run_o = running & cm0_r[`SMOSD_CM0_SUBEN]; // see RQ1
  assign low_osc_run_o = running & ~cm1_r[`SMOSD_CM1_LOWOFF]; // see RQ1
  assign fast_osc_run_o = running & fra_r[`SMOSD_FRA_ON]; // see RQ1
  assign fast_osc_sel_o = fra_r[`SMOSD_FRA_SEL];
  assign main_high_drive_o = cm1_r[`SMOSD_CM1_MAINDRV];
  assign sub_high_drive_o = cm0_r[`SMOSD_CM0_SUBDRV];
  // cpu clock gated until the settle count ends
  assign cpu_clk_run_o = (state_r == ST_RUN); // see RQ1
  assign periph_clk_run_o = (state_r == ST_RUN); // see RQ1
  // div8 forced at entry, so wake resumes slow
  assign cpu_div8_o = cm0_r[`SMOSD_CM0_DIV8]; // see RQ15
  assign cpu_fallback_o = osd_r[`SMOSD_OSD_FALLBK];

  // port latches frozen until the cpu clock runs again
  assign pin_hold_o = (state_r != ST_RUN); // see RQ9
  // oscillator output pins: driven high or released
  assign main_osc_pin_o = 1'b1;
  assign main_osc_pin_oe_o = (state_r != ST_RUN) & ~cm0_r[`SMOSD_CM0_SUBSEL] &
                             cm1_r[`SMOSD_CM1_PINSEL]; // see RQ10
  assign sub_osc_pin_o = 1'b1;
  assign sub_osc_pin_oe_o = (state_r != ST_RUN) & cm0_r[`SMOSD_CM0_SUBSEL] &
                            cm0_r[`SMOSD_CM0_SUBEN]; // see RQ11
endmodule // smosd_stop_ctrl

// *** smosd_sync2.v ***
`timescale 1ns/1ps
module smosd_sync2 #(
  parameter W = 1
) (
  input wire clk_i, // system clock
  input wire reset_i, // sync reset
  input wire [W-1:0] d_i, // async inputs
  output wire [W-1:0] q_o // synced outputs
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  // first stage feeds only the second
  always @(posedge clk_i) begin
    if (reset_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // smosd_sync2

// *** smosd_xtal_model.sv ***
`timescale 1ns/1ps
// main crystal: toggles only while enabled and not failed
module smosd_xtal_model #(
  parameter HALF_NS = 40 // 12.5 MHz, well above the 2 MHz floor
) (
  input wire run_i, // oscillator enable
  input wire fail_i, // external failure
  output logic xtal_o // crystal level
);
  initial xtal_o = 1'b0;
  // a stopped crystal stands at its last level
  always begin
    #HALF_NS;
    if (run_i && !fail_i) xtal_o <= ~xtal_o;
  end
endmodule // smosd_xtal_model

// *** stop_mode_osc_stop_detect_test.sv ***
`timescale 1ns/1ps
`include "smosd_consts.vh"
module stop_mode_osc_stop_detect_test;
  logic clk_i = 0, reset_i = 1, hsel = 0, hwrite = 0, wdg = 0, fail = 0;
  logic [7:0] haddr = 0, src = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, rd;
  wire [31:0] hrdata;
  wire [7:0] wsrc;
  wire hrdy, xtal, mrun, lrun, fb, moe, soe, wirq, oirq, nmi, crun, div8, frun, fsel;
  int bad_count = 0, check_count = 0;
  initial forever #10 clk_i = ~clk_i;
  smosd_stop_ctrl #(.WATCH_CYC(8), .SETTLE_CYC(4)) smosd_stop_ctrl_i (.clk_i(clk_i), .reset_i(reset_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hrdata_o(hrdata), .hresp_o(), .key_irq_i(src[0]), .ext_irq_0_i(src[1]),
    .ext_irq_1_i(src[2]), .ext_irq_3_i(src[3]), .event_timer_irq_i(src[4]), .serial_irq_i(src[5]),
    .vmon1_irq_i(src[6]), .vmon2_irq_i(src[7]), .watchdog_irq_i(wdg), .main_clock_in_i(xtal),
    .main_osc_run_o(mrun), .sub_osc_run_o(), .low_osc_run_o(lrun), .fast_osc_run_o(frun), .fast_osc_sel_o(fsel),
    .main_high_drive_o(), .sub_high_drive_o(), .cpu_clk_run_o(crun), .periph_clk_run_o(), .cpu_div8_o(div8),
    .cpu_fallback_o(fb), .pin_hold_o(), .main_osc_pin_o(), .main_osc_pin_oe_o(moe), .sub_osc_pin_o(),
    .sub_osc_pin_oe_o(soe), .wake_irq_o(wirq), .wake_src_o(wsrc), .osc_stop_irq_o(oirq), .nmi_o(nmi));
  smosd_xtal_model smosd_xtal_model_i (.run_i(mrun), .fail_i(fail), .xtal_o(xtal));
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait on ready (0), wake pulse (1) or detect pulse (2)
  task wt(input int w);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((w == 0 ? hrdy : w == 1 ? wirq : oirq) !== 1'b1 && n < 60);
    if (n >= 60) begin
      bad_count++;
      $display("[FAIL] wait %0d expected pulse seen timeout", w);
      print_verdict;
    end
  endtask
  // one single ahb transfer, address phase then data phase
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt(0);
    htrans <= 2'h0;
    hwdata <= d;
    wt(0);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc("cm0", `SMOSD_A_CM0, 32'h48);
    rdc("cm1", `SMOSD_A_CM1, 32'h20);
    rdc("hole", 8'h20, 32'h0);
    $display("test reset done");
    // filtered or internally clocked sources must not wake
    wr(`SMOSD_A_OSD, 32'h0);
    wr(`SMOSD_A_CM0, 32'h12);
    wr(`SMOSD_A_CM1, 32'h08);
    wr(`SMOSD_A_WAKE, 32'hff1b);
    wr(`SMOSD_A_CM1, 32'h09);
    repeat (2) @(posedge clk_i);
    chk("crun", 0, crun);
    chk("soe", 1, soe);
    src <= 8'hfe;
    repeat (20) @(posedge clk_i);
    chk("gated", 0, crun);
    src <= 8'h01;
    wt(1);
    chk("key", 8'h01, wsrc);
    src <= 8'h0;
    rdc("cm0w", `SMOSD_A_CM0, 32'h5a);
    rdc("cm1w", `SMOSD_A_CM1, 32'h28);
    $display("test gating done");
    // each qualified source wakes on its own
    wr(`SMOSD_A_CM0, 32'h0);
    wr(`SMOSD_A_VM1, 32'h02);
    wr(`SMOSD_A_VM2, 32'h02);
    wr(`SMOSD_A_WAKE, 32'hff60);
    for (int k = 0; k < 8; k++) begin
      wr(`SMOSD_A_CM1, k[0] ? 32'h01 : 32'h09);
      repeat (2) @(posedge clk_i);
      chk("moe", k[0] ? 0 : 1, moe);
      chk("mrun", 0, mrun);
      src <= 8'h01 << k;
      wt(1);
      chk("wsrc", 8'h01 << k, wsrc);
      chk("div8", 1, div8);
      src <= 8'h0;
    end
    $display("test wake done");
    // shared vector flags
    wr(`SMOSD_A_VM1, 32'h02);
    wr(`SMOSD_A_VM2, 32'h02);
    @(posedge clk_i);
    chk("nmi0", 0, nmi);
    wdg <= 1'b1;
    repeat (5) @(posedge clk_i);
    wdg <= 1'b0;
    chk("nmiw", 1, nmi);
    rdc("vm2", `SMOSD_A_VM2, 32'h0a);
    $display("test vector done");
    // detector: disarmed with 01b, fires with 11b
    wr(`SMOSD_A_VM2, 32'h02);
    wr(`SMOSD_A_CM1, 32'h10);
    wr(`SMOSD_A_FRA, 32'h3);
    @(posedge clk_i);
    chk("fsel", 1, fsel);
    chk("frun", 1, frun);
    wr(`SMOSD_A_FRA, 32'h0);
    @(posedge clk_i);
    chk("fsel0", 0, fsel);
    wr(`SMOSD_A_OSD, 32'h01);
    fail <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk("nodet", 0, fb);
    wr(`SMOSD_A_OSD, 32'h03);
    wt(2);
    chk("lrun", 1, lrun);
    rdc("osd", `SMOSD_A_OSD, 32'h0f);
    rdc("cm1d", `SMOSD_A_CM1, 32'h0);
    fail <= 1'b0;
    wr(`SMOSD_A_OSD, 32'h0);
    @(posedge clk_i);
    chk("nmix", 0, nmi);
    $display("test detect done");
    print_verdict;
  end
endmodule // stop_mode_osc_stop_detect_test
